// ===== rtl/abfp_pkg.sv
// Package with constants and types shared by the async byte FIFO port.
package abfp_pkg;
   localparam int unsigned DATA_W         = 8;
   localparam int unsigned RX_DEPTH       = 16;
   localparam int unsigned TX_DEPTH       = 16;
   localparam logic [1:0]  MODE_NONE      = 2'h0;
   localparam logic [1:0]  MODE_CHAN_A    = 2'h1;
   localparam logic [1:0]  MODE_CHAN_B    = 2'h2;
   localparam logic [1:0]  MODE_BOTH      = 2'h3;
   localparam logic        FLAG_RESET     = 1'h1;
   localparam logic [7:0]  DATA_RESET     = 8'h00;
   localparam logic        POWER_OK_NORMAL = 1'h0;
   typedef enum logic [1:0] {abfp_idle, abfp_read, abfp_write} abfp_state_t;
endpackage

// ===== rtl/abfp_fifo.sv
// Small synchronous FIFO used for the receive and transmit buffers.
`timescale 1ns/1ps
module abfp_fifo #(
   parameter int unsigned WIDTH = 8,
   parameter int unsigned DEPTH = 16
) (
   input  wire logic             clock,
   input  wire logic             rstn,
   input  wire logic             push,
   input  wire logic [WIDTH-1:0] push_data,
   input  wire logic             pop,
   output logic      [WIDTH-1:0] head,
   output logic                  empty,
   output logic                  full
);
   localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0]    rd_ptr;
   logic [AW-1:0]    wr_ptr;
   logic [AW:0]      count;
   logic [AW-1:0]    next_rd_ptr;
   logic [AW-1:0]    next_wr_ptr;
   logic [AW:0]      next_count;
   logic             do_push;
   logic             do_pop;

   always_comb begin
      do_push     = push && !full;
      do_pop      = pop && !empty;
      next_rd_ptr = rd_ptr;
      next_wr_ptr = wr_ptr;
      next_count  = count;
      if (do_push) begin
         next_wr_ptr = (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
      end
      if (do_pop) begin
         next_rd_ptr = (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
      end
      if (do_push && !do_pop) begin
         next_count = count + 1'b1;
      end else if (do_pop && !do_push) begin
         next_count = count - 1'b1;
      end
   end

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         rd_ptr <= '0;
         wr_ptr <= '0;
         count  <= '0;
      end else begin
         rd_ptr <= next_rd_ptr;
         wr_ptr <= next_wr_ptr;
         count  <= next_count;
      end
   end

   // Storage has no reset; contents are only read once counted in.
   always_ff @(posedge clock) begin
      if (do_push) begin
         mem[wr_ptr] <= push_data;
      end
   end

   assign head  = mem[rd_ptr];
   assign empty = (count == '0);
   assign full  = (count == (AW+1)'(DEPTH));
endmodule // abfp_fifo

// ===== rtl/abfp_port.sv
// Asynchronous byte FIFO port for one channel, strobe driven by an external controller.
// What this block and its controller do
// RULE_01: Port works only when configuration selects this channel; the wake strobe still raises resume_req and flush_req whatever cfg_mode holds.
// RULE_02: Falling strobe edges start reads and perform writes.
// RULE_03: Data bus is input unless read strobe low.
// RULE_04: Data-available flag low while receive buffer nonempty.
// RULE_05: Flag goes high after read; relowers if more.
// RULE_06: Flags undriven during reset, pulled high.
// RULE_07: Space-available flag low while transmit buffer has room.
// RULE_08: Read fall presents receive head byte on bus.
// RULE_09: Read rise pops presented byte, advances buffer.
// RULE_10: Write fall captures bus byte into transmit buffer.
// RULE_11: Suspended with wakeup enabled, wake strobe requests resume.
// RULE_12: Controller holds wake input high before strobing.
// RULE_13: Normal operation, strobe flushes transmit data next IN.
// RULE_14: Controller never asserts both strobes together.
`timescale 1ns/1ps
module abfp_port #(
   parameter int unsigned  RX_DEPTH = abfp_pkg::RX_DEPTH,
   parameter int unsigned  TX_DEPTH = abfp_pkg::TX_DEPTH,
   parameter logic         CHANNEL  = 1'h0
) (
   input  wire logic       clock,
   input  wire logic       rstn,
   input  wire logic [1:0] cfg_mode,
   input  wire logic       cfg_wakeup_en,
   input  wire logic       power_ok_n,
   input  wire logic       rd_n,
   input  wire logic       wr_n,
   input  wire logic       send_now_wake_n,
   input  wire logic [7:0] chan_data_in,
   output logic      [7:0] chan_data_out,
   output logic            chan_data_oe,
   output logic            rx_avail_n,
   output logic            rx_avail_oe,
   output logic            tx_space_n,
   output logic            tx_space_oe,
   input  wire logic       rx_in_valid,
   input  wire logic [7:0] rx_in_data,
   output logic            rx_in_ready,
   output logic            tx_out_valid,
   output logic      [7:0] tx_out_data,
   input  wire logic       tx_out_ready,
   output logic            resume_req,
   output logic            flush_req
);
   logic                  enabled;
   logic                  rd_q;
   logic                  wr_q;
   logic                  wake_q;
   logic                  next_rd_q;
   logic                  next_wr_q;
   logic                  next_wake_q;
   logic                  rd_fall;
   logic                  rd_rise;
   logic                  wr_fall;
   logic                  wake_fall;
   logic                  rx_empty;
   logic                  rx_full;
   logic                  tx_empty;
   logic                  tx_full;
   logic [7:0]            rx_head;
   logic [7:0]            tx_head;
   logic                  rx_pop;
   logic                  rx_push;
   logic                  tx_push;
   logic                  tx_pop;
   abfp_pkg::abfp_state_t state;
   abfp_pkg::abfp_state_t next_state;
   logic [7:0]            next_chan_data_out;
   logic                  next_chan_data_oe;
   logic                  next_rx_avail_n;
   logic                  next_rx_avail_oe;
   logic                  next_tx_space_n;
   logic                  next_tx_space_oe;
   logic                  next_rx_in_ready;
   logic                  next_tx_out_valid;
   logic [7:0]            next_tx_out_data;
   logic                  next_resume_req;
   logic                  next_flush_req;

   // Each channel answers to its own mode code and to the code for both.
   assign enabled = (cfg_mode == abfp_pkg::MODE_BOTH) ||
                    (cfg_mode == (CHANNEL ? abfp_pkg::MODE_CHAN_B : abfp_pkg::MODE_CHAN_A)); // see RULE_01

   // Strobe history registers; they reset to the idle high level so no false edge follows reset.
   always_comb begin
      next_rd_q   = rd_n;
      next_wr_q   = wr_n;
      next_wake_q = send_now_wake_n;
   end

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         rd_q   <= 1'h1;
         wr_q   <= 1'h1;
         wake_q <= 1'h1;
      end else begin
         rd_q   <= next_rd_q;
         wr_q   <= next_wr_q;
         wake_q <= next_wake_q;
      end
   end

   assign rd_fall   = rd_q && !rd_n; // see RULE_02
   assign rd_rise   = !rd_q && rd_n;
   assign wr_fall   = wr_q && !wr_n; // see RULE_02
   assign wake_fall = wake_q && !send_now_wake_n;

   // Receive buffer, filled from the far side and emptied by the read strobe.
   abfp_fifo #(
      .WIDTH (abfp_pkg::DATA_W),
      .DEPTH (RX_DEPTH)
   ) rx_buf (
      .clock     (clock),
      .rstn      (rstn),
      .push      (rx_push),
      .push_data (rx_in_data),
      .pop       (rx_pop),
      .head      (rx_head),
      .empty     (rx_empty),
      .full      (rx_full)
   );

   // Transmit buffer, filled by the write strobe and drained toward the far side.
   abfp_fifo #(
      .WIDTH (abfp_pkg::DATA_W),
      .DEPTH (TX_DEPTH)
   ) tx_buf (
      .clock     (clock),
      .rstn      (rstn),
      .push      (tx_push),
      .push_data (chan_data_in),
      .pop       (tx_pop),
      .head      (tx_head),
      .empty     (tx_empty),
      .full      (tx_full)
   );

   // Ready is registered, so it drops for one cycle after every accepted byte.
   // This halves the fill rate but guarantees the buffer is never offered a byte while full.
   assign rx_push = rx_in_valid && rx_in_ready;
   assign tx_pop  = !tx_empty && (!tx_out_valid || tx_out_ready);

   always_comb begin
      next_state         = state;
      next_chan_data_out = chan_data_out;
      next_chan_data_oe  = chan_data_oe;
      rx_pop             = 1'b0;
      tx_push            = 1'b0;
      case (state)
         abfp_pkg::abfp_idle: begin
            if (enabled && rd_fall && !rx_empty) begin
               next_state         = abfp_pkg::abfp_read;
               next_chan_data_out = rx_head; // see RULE_08
               next_chan_data_oe  = 1'b1; // see RULE_03
            end else if (enabled && wr_fall && !tx_full) begin
               tx_push    = 1'b1; // see RULE_10
               next_state = abfp_pkg::abfp_write;
            end
         end
         abfp_pkg::abfp_read: begin
            if (rd_rise || !enabled) begin
               rx_pop            = rd_rise; // see RULE_09
               next_chan_data_oe = 1'b0; // see RULE_03
               next_state        = abfp_pkg::abfp_idle;
            end
         end
         abfp_pkg::abfp_write: begin
            // A new write needs the strobe to go high again first.
            if (wr_n) begin
               next_state = abfp_pkg::abfp_idle;
            end
         end
         default: begin
            next_state        = abfp_pkg::abfp_idle;
            next_chan_data_oe = 1'b0;
         end
      endcase

      // The flag stays high through a read and for the cycle after it, while the pop settles.
      next_rx_avail_n  = !enabled || rx_empty || (state == abfp_pkg::abfp_read) ||
                         (next_state == abfp_pkg::abfp_read); // see RULE_04, RULE_05
      next_rx_avail_oe = 1'b1; // see RULE_06
      next_tx_space_n  = !enabled || tx_full || tx_push; // see RULE_07
      next_tx_space_oe = 1'b1; // see RULE_06
      next_rx_in_ready = !rx_full && !rx_push;
      next_tx_out_valid = tx_out_valid;
      next_tx_out_data  = tx_out_data;
      if (tx_pop) begin
         next_tx_out_valid = 1'b1;
         next_tx_out_data  = tx_head;
      end else if (tx_out_ready) begin
         next_tx_out_valid = 1'b0;
      end
      next_resume_req = wake_fall && power_ok_n && cfg_wakeup_en; // see RULE_11
      next_flush_req  = wake_fall && (power_ok_n == abfp_pkg::POWER_OK_NORMAL); // see RULE_13
   end

   // Flag enables stay low in reset so the pins float to their pull-up level.
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         state         <= abfp_pkg::abfp_idle;
         chan_data_out <= abfp_pkg::DATA_RESET;
         chan_data_oe  <= 1'b0;
         rx_avail_n    <= abfp_pkg::FLAG_RESET;
         rx_avail_oe   <= 1'b0;
         tx_space_n    <= abfp_pkg::FLAG_RESET;
         tx_space_oe   <= 1'b0;
         rx_in_ready   <= 1'b0;
         tx_out_valid  <= 1'b0;
         tx_out_data   <= abfp_pkg::DATA_RESET;
         resume_req    <= 1'b0;
         flush_req     <= 1'b0;
      end else begin
         state         <= next_state;
         chan_data_out <= next_chan_data_out;
         chan_data_oe  <= next_chan_data_oe;
         rx_avail_n    <= next_rx_avail_n;
         rx_avail_oe   <= next_rx_avail_oe;
         tx_space_n    <= next_tx_space_n;
         tx_space_oe   <= next_tx_space_oe;
         rx_in_ready   <= next_rx_in_ready;
         tx_out_valid  <= next_tx_out_valid;
         tx_out_data   <= next_tx_out_data;
         resume_req    <= next_resume_req;
         flush_req     <= next_flush_req;
      end
   end
endmodule // abfp_port

// ===== sim/abfp_port_props.sv
// Checker of the port pins of the async byte FIFO port.
`timescale 1ns/1ps
module abfp_port_props (
   input wire logic       clock, rstn, rd_n, wr_n, send_now_wake_n, power_ok_n, cfg_wakeup_en,
   input wire logic [1:0] cfg_mode,
   input wire logic       chan_data_oe, rx_avail_n, rx_avail_oe, tx_space_n, tx_space_oe,
   input wire logic       tx_out_valid, resume_req, flush_req
);
   default clocking @(posedge clock); endclocking
   default disable iff (!rstn);
   // Two cycles of slack allow for strobe synchronisers.
   a_bus_drive: assert property (chan_data_oe |-> !rd_n || !$past(rd_n) || !$past(rd_n, 2)) else $error("bus");
   a_read_oe: assert property ($fell(rd_n) && !rx_avail_n |-> ##[1:4] chan_data_oe) else $error("no data");
   a_rx_release: assert property ($rose(rd_n) |-> ##[0:3] rx_avail_n) else $error("flag");
   a_tx_push: assert property ($fell(wr_n) && !tx_space_n |-> ##[1:8] tx_out_valid) else $error("push");
   a_mode_off: assert property ((cfg_mode == abfp_pkg::MODE_NONE) [*3] |-> !chan_data_oe) else $error("mode");
   a_wake_resume: assert property ($fell(send_now_wake_n) && power_ok_n && cfg_wakeup_en |-> ##[1:6] resume_req)
      else $error("resume");
   a_send_flush: assert property ($fell(send_now_wake_n) && !power_ok_n |-> ##[1:6] flush_req) else $error("flush");
   a_reset_float: assert property (@(posedge clock) disable iff (1'b0) !rstn |-> !rx_avail_oe && !tx_space_oe)
      else $error("reset");
endmodule // abfp_port_props
bind abfp_port abfp_port_props props (
   .clock(clock), .rstn(rstn), .rd_n(rd_n), .wr_n(wr_n), .send_now_wake_n(send_now_wake_n),
   .power_ok_n(power_ok_n), .cfg_wakeup_en(cfg_wakeup_en), .cfg_mode(cfg_mode), .chan_data_oe(chan_data_oe),
   .rx_avail_n(rx_avail_n), .rx_avail_oe(rx_avail_oe), .tx_space_n(tx_space_n), .tx_space_oe(tx_space_oe),
   .tx_out_valid(tx_out_valid), .resume_req(resume_req), .flush_req(flush_req)
);

// ===== sim/abfp_usb_model.sv
// Far-side model: supplies receive bytes and drains transmit bytes with stalls.
`timescale 1ns/1ps
module abfp_usb_model (
   input  wire logic       clock, rstn, rx_in_ready,
   output logic            rx_in_valid, tx_out_ready,
   output logic      [7:0] rx_in_data
);
   logic [7:0] k;
   always_ff @(posedge clock or negedge rstn)
      if (!rstn) begin k <= 8'h10; tx_out_ready <= 1'h0; end
      else begin k <= k + 8'(rx_in_ready); tx_out_ready <= ~tx_out_ready; end
   assign rx_in_valid = rstn;
   assign rx_in_data  = rx_in_valid ? k : ~k;
endmodule // abfp_usb_model

// ===== sim/test_async_byte_fifo_port.sv
// Self-checking bench of the async byte FIFO port.
`timescale 1ns/1ps
`define CHK(a,b) begin n_checks++; if ((a)!==(b)) begin bad_count++; $display("mismatch %0t %h",$time,a); end end
module test_async_byte_fifo_port;
   logic clock=0, rstn=0, rd_n=1, wr_n=1, power_ok_n=0, send_now_wake_n=1, cfg_wakeup_en=1;
   logic chan_data_oe, rx_avail_n, rx_avail_oe, tx_space_n, tx_space_oe, rx_in_valid, rx_in_ready;
   logic tx_out_valid, tx_out_ready, resume_req, flush_req;
   logic [1:0] cfg_mode = abfp_pkg::MODE_BOTH;
   logic [7:0] chan_data_in, chan_data_out, rx_in_data, tx_out_data, wd=8'h00, re=8'h10, q[$];
   logic [31:0] s = 32'hca5c0256;
   int bad_count=0, n_checks=0, n_resume=0, n_flush=0;
   wire rxf = rx_avail_oe ? rx_avail_n : 1'h1;
   wire txf = tx_space_oe ? tx_space_n : 1'h1;
   assign chan_data_in = chan_data_oe ? chan_data_out : (rd_n ? wd : ~wd);
   abfp_port DUT (
      .clock(clock), .rstn(rstn), .cfg_mode(cfg_mode), .cfg_wakeup_en(cfg_wakeup_en), .power_ok_n(power_ok_n),
      .rd_n(rd_n), .wr_n(wr_n), .send_now_wake_n(send_now_wake_n), .chan_data_in(chan_data_in),
      .chan_data_out(chan_data_out), .chan_data_oe(chan_data_oe), .rx_avail_n(rx_avail_n),
      .rx_avail_oe(rx_avail_oe), .tx_space_n(tx_space_n), .tx_space_oe(tx_space_oe), .rx_in_valid(rx_in_valid),
      .rx_in_data(rx_in_data), .rx_in_ready(rx_in_ready), .tx_out_valid(tx_out_valid),
      .tx_out_data(tx_out_data), .tx_out_ready(tx_out_ready), .resume_req(resume_req), .flush_req(flush_req)
   );
   abfp_usb_model far (
      .clock(clock), .rstn(rstn), .rx_in_ready(rx_in_ready), .rx_in_valid(rx_in_valid),
      .tx_out_ready(tx_out_ready), .rx_in_data(rx_in_data)
   );
   initial forever #20 clock = ~clock;
   function automatic logic [31:0] xs(logic [31:0] v); v^=v<<13; v^=v>>17; return v^(v<<5); endfunction
   task automatic close_out;
      $display("checks %0d mismatches %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   task automatic hold(input bit r);
      for (int i = 0; i < 60 && (r ? rxf : txf); i++) @(posedge clock);
      if (r) `CHK(rxf, 1'h0)
      else `CHK(txf, 1'h0)
      if (r ? !rxf : !txf) begin
         if (r) rd_n <= 0; else wr_n <= 0;
         repeat (4) @(posedge clock);
         if (r) `CHK(chan_data_oe, 1'h1)
         if (r) `CHK(chan_data_out, re)
         if (r) re++;
         rd_n <= 1; wr_n <= 1;
         repeat (4) @(posedge clock);
      end
   endtask
   task automatic wake;
      send_now_wake_n <= 0; repeat (4) @(posedge clock);
      send_now_wake_n <= 1; repeat (8) @(posedge clock);
   endtask
   always @(posedge clock) if (tx_out_valid && tx_out_ready) `CHK(tx_out_data, q.pop_front())
   always @(posedge clock) begin
      if (resume_req) n_resume++;
      if (flush_req) n_flush++;
   end
   initial begin
      repeat (20) @(posedge clock);
      `CHK({rxf, txf, rx_avail_oe, tx_space_oe}, 4'hc)
      rstn <= 1; repeat (4) @(posedge clock);
      repeat (30) begin
         s = xs(s);
         if (s[0]) hold(1);
         else begin wd <= s[15:8]; q.push_back(s[15:8]); hold(0); end
      end
      wake; power_ok_n <= 1; wake;
      repeat (40) @(posedge clock);
      `CHK(q.size(), 0)
      `CHK(n_flush, 1)
      `CHK(n_resume, 1)
      cfg_mode <= abfp_pkg::MODE_NONE;
      repeat (4) @(posedge clock);
      `CHK({rxf, txf, chan_data_oe}, 3'h6)
      close_out;
   end
   initial begin #100us; bad_count++; close_out; end
endmodule // test_async_byte_fifo_port
